// ==== atce_engine.sv ====
// Overview of operation
// - static entries are never removed by ageing
// - entry state bit one selects multicast index
// - unicast hit returns stored port as egress
// - multicast hit fetches port map by index
// - operation decoded from command and control together
// - command 000/0111 creates a new entry
// - command 000/1111 overwrites a present entry
// - command 001/1111 erases a present entry
// - command 010/0000 searches an empty location
// - command 010/1001 searches by output port
// - command 010/1010 searches by forwarding group
// - command 010/1100 searches by MAC address
// - command 010/1110 searches by address and group
// - command 010/1101 searches by address and port
// - command 010/1011 searches by group and port
// - command 010/1111 searches by all three fields
// - command 011/0100 sets walk position from address
// - command 011/0000 resets walk to first entry
// - successful field search returns matched entry fields; empty search returns zeros
// - occupancy bit reports whether searched entry exists
//
// Added by the designer: register access over APB and the placing of the registers.
`default_nettype none
module atce_engine
   import atce_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic [ATCE_AW-1:0]    paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  age_tick,
   input  wire logic                  lu_req,
   input  wire logic [47:0]           lu_mac,
   input  wire logic [4:0]            lu_fg,
   output logic                       lu_valid,
   output logic                       lu_hit,
   output logic                       lu_mcast,
   output logic      [4:0]            lu_port,
   output logic      [ATCE_NPORT-1:0] lu_map,
   output logic      [4:0]            mc_idx,
   input  wire logic [ATCE_NPORT-1:0] mc_map_data
);

   atce_regs_t r_reg;
   atce_regs_t r_next;

   atce_match_if cm_if ();
   atce_match_if ex_if ();
   atce_match_if lu_if ();

   atce_matcher u_cmd_match   (.m(cm_if));
   atce_matcher u_exist_match (.m(ex_if));
   atce_matcher u_look_match  (.m(lu_if));

   // decode needs both fields; neither alone names an operation
   function automatic atce_op_t atce_decode(input logic [2:0] cmd, input logic [3:0] ctl);
      atce_op_t op;
      op = ATCE_OP_NONE;
      if (cmd == ATCE_CMD_WRITE && ctl == ATCE_CTL_CREATE) begin
         op = ATCE_OP_CREATE;
      end else if (cmd == ATCE_CMD_WRITE && ctl == ATCE_CTL_OVERWRITE) begin
         op = ATCE_OP_OVERWRITE;
      end else if (cmd == ATCE_CMD_ERASE && ctl == ATCE_CTL_ERASE) begin
         op = ATCE_OP_ERASE;
      end else if (cmd == ATCE_CMD_SEARCH && ctl == ATCE_CTL_EMPTY) begin
         op = ATCE_OP_SR_EMPTY;
      end else if (cmd == ATCE_CMD_SEARCH && ctl[ATCE_SEL_FIELD_BIT] && ctl[2:0] != 3'h0) begin
         op = ATCE_OP_SR_FIELD;
      end else if (cmd == ATCE_CMD_WALK && ctl == ATCE_CTL_WALK_ADDR) begin
         op = ATCE_OP_WALK_ADDR;
      end else if (cmd == ATCE_CMD_WALK && ctl == ATCE_CTL_WALK_FIRST) begin
         op = ATCE_OP_WALK_FIRST;
      end
      return op;
   endfunction

   atce_entry_t          key;
   logic [3:0]           opsel;
   atce_op_t             op;
   logic                 exec;
   logic                 busy;
   logic                 apb_acc;
   logic [ATCE_IDXW-1:0] cm_idx;
   logic [ATCE_IDXW-1:0] ex_idx;
   logic [ATCE_IDXW-1:0] lu_idx;

   assign key.valid = 1'b1;
   assign key.state = r_reg.ctrl1[ATCE_CTL_STATE_LSB +: 2];
   assign key.port  = r_reg.ctrl1[ATCE_CTL_PORT_LSB +: 5];
   assign key.fg    = r_reg.ctrl1[ATCE_CTL_FG_LSB +: 5];
   assign key.mac   = {r_reg.ctrl1[15:0], r_reg.ctrl0};
   assign opsel     = r_reg.ctrl1[ATCE_CTL_OPSEL_LSB +: 4];
   assign op        = atce_decode(r_reg.ctrl2, opsel);
   assign exec      = (r_reg.fsm == ATCE_EXEC);
   assign busy      = exec;
   assign apb_acc   = psel && penable && !r_reg.ready;
   assign cm_idx    = cm_if.hit_idx;
   assign ex_idx    = ex_if.hit_idx;
   assign lu_idx    = lu_if.hit_idx;

   // command matcher: free slot for create, field search from the walk position
   assign cm_if.tbl       = r_reg.tbl;
   assign cm_if.key       = key;
   assign cm_if.use_mac   = opsel[ATCE_SEL_MAC_BIT];
   assign cm_if.use_fg    = opsel[ATCE_SEL_FG_BIT];
   assign cm_if.use_port  = opsel[ATCE_SEL_PORT_BIT];
   assign cm_if.find_free = (op == ATCE_OP_CREATE) || (op == ATCE_OP_SR_EMPTY);
   assign cm_if.start     = (op == ATCE_OP_CREATE) ? '0 : r_reg.walk;

   // existence check by address and group, whole table
   assign ex_if.tbl       = r_reg.tbl;
   assign ex_if.key       = key;
   assign ex_if.use_mac   = 1'b1;
   assign ex_if.use_fg    = 1'b1;
   assign ex_if.use_port  = 1'b0;
   assign ex_if.find_free = 1'b0;
   assign ex_if.start     = '0;

   // frame lookup: same address and same forwarding group
   assign lu_if.tbl       = r_reg.tbl;
   assign lu_if.key       = '{valid: 1'b1, state: 2'h0, port: 5'h00, fg: lu_fg, mac: lu_mac};
   assign lu_if.use_mac   = 1'b1;
   assign lu_if.use_fg    = 1'b1;
   assign lu_if.use_port  = 1'b0;
   assign lu_if.find_free = 1'b0;
   assign lu_if.start     = '0;

   always_comb begin
      logic [31:0] rd;
      logic [31:0] st1;
      rd  = 32'h0000_0000;
      st1 = 32'h0000_0000;
      r_next = r_reg;
      r_next.ready  = 1'b0;
      r_next.slverr = 1'b0;

      st1[15:0]                        = r_reg.res.mac[47:32];
      st1[ATCE_ST_FG_LSB +: 5]         = r_reg.res.fg;
      st1[ATCE_ST_PORT_LSB +: 5]       = r_reg.res.port;
      st1[ATCE_ST_OCC_BIT]             = r_reg.res.valid;
      st1[ATCE_ST_STATE_LSB +: 2]      = r_reg.res.state;
      st1[ATCE_ST_BAD_BIT]             = 1'b0; // no bad entries in flop storage

      // one wait state on every access keeps pready a flop
      if (apb_acc) begin
         r_next.ready = 1'b1;
         if (paddr == ATCE_ADDR_CTRL0) begin
            rd = r_reg.ctrl0;
            if (pwrite) begin
               r_next.ctrl0 = pwdata;
            end
         end else if (paddr == ATCE_ADDR_CTRL1) begin
            rd = r_reg.ctrl1;
            if (pwrite) begin
               r_next.ctrl1 = pwdata;
            end
         end else if (paddr == ATCE_ADDR_CTRL2) begin
            rd = {29'h0, r_reg.ctrl2};
            // a start while busy is dropped; the host is expected to poll first
            if (pwrite && !busy) begin
               r_next.ctrl2 = pwdata[2:0];
               r_next.fsm   = ATCE_EXEC;
            end
         end else if (paddr == ATCE_ADDR_STAT0) begin
            rd = r_reg.res.mac[31:0];
         end else if (paddr == ATCE_ADDR_STAT1) begin
            rd = st1;
         end else if (paddr == ATCE_ADDR_STAT2) begin
            rd = {28'h0, busy, r_reg.result};
         end else begin
            r_next.slverr = 1'b1;
         end
         r_next.rdata = pwrite ? 32'h0000_0000 : rd;
      end

      // ageing spares static entries
      if (age_tick) begin
         for (int i = 0; i < ATCE_DEPTH; i++) begin
            if (!r_reg.tbl[i].state[0]) begin
               r_next.tbl[i].valid = 1'b0;
            end
         end
      end

      // commands run after ageing so a same-cycle write is kept
      if (exec) begin
         r_next.fsm    = ATCE_IDLE;
         r_next.result = ATCE_RES_OK;
         case (op)
            ATCE_OP_CREATE: begin
               if (ex_if.hit_any) begin
                  r_next.result = ATCE_RES_EXISTS;
               end else if (cm_if.hit_any) begin
                  r_next.tbl[cm_idx] = key;
               end else begin
                  r_next.result = ATCE_RES_FULL;
               end
            end
            ATCE_OP_OVERWRITE: begin
               if (ex_if.hit_any) begin
                  r_next.tbl[ex_idx] = key;
               end else begin
                  r_next.result = ATCE_RES_NOTFOUND;
               end
            end
            ATCE_OP_ERASE: begin
               if (ex_if.hit_any) begin
                  r_next.tbl[ex_idx].valid = 1'b0;
               end else begin
                  r_next.result = ATCE_RES_NOTFOUND;
               end
            end
            ATCE_OP_SR_EMPTY, ATCE_OP_SR_FIELD: begin
               if (cm_if.hit_any) begin
                  // empty slot reports occupancy zero
                  r_next.res  = (op == ATCE_OP_SR_EMPTY) ? '0 : r_reg.tbl[cm_idx];
                  r_next.walk = cm_idx + ATCE_IDXW'(1);
               end else begin
                  r_next.res.valid = 1'b0;
                  r_next.result    = ATCE_RES_NOTFOUND;
                  r_next.walk      = '0;
               end
            end
            ATCE_OP_WALK_ADDR: begin
               r_next.walk = key.mac[ATCE_IDXW-1:0];
            end
            ATCE_OP_WALK_FIRST: begin
               r_next.walk = '0;
            end
            default: begin
               r_next.result = ATCE_RES_BADCMD;
            end
         endcase
      end

      // two-stage lookup; stage one drives the map index out
      r_next.s1_valid = lu_req;
      r_next.s1_hit   = lu_if.hit_any;
      r_next.s1_mcast = lu_if.hit_any && r_reg.tbl[lu_idx].state[1];
      r_next.s1_port  = lu_if.hit_any ? r_reg.tbl[lu_idx].port : 5'h00; // miss shows port zero
      r_next.lu_valid = r_reg.s1_valid;
      r_next.lu_hit   = r_reg.s1_hit;
      r_next.lu_mcast = r_reg.s1_mcast;
      r_next.lu_port  = r_reg.s1_port;
      if (!r_reg.s1_hit) begin
         r_next.lu_map = '0;
      end else if (r_reg.s1_mcast) begin
         r_next.lu_map = mc_map_data;
      end else begin
         r_next.lu_map = ATCE_NPORT'(1) << r_reg.s1_port;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg       <= '0;
         r_reg.fsm   <= ATCE_IDLE;
         r_reg.ctrl0 <= ATCE_CTRL_RST;
         r_reg.ctrl1 <= ATCE_CTRL_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata   = r_reg.rdata;
   assign pready   = r_reg.ready;
   assign pslverr  = r_reg.slverr;
   assign lu_valid = r_reg.lu_valid;
   assign lu_hit   = r_reg.lu_hit;
   assign lu_mcast = r_reg.lu_mcast;
   assign lu_port  = r_reg.lu_port;
   assign lu_map   = r_reg.lu_map;
   assign mc_idx   = r_reg.s1_port;

   // checking helpers
   logic [ATCE_DEPTH-1:0] static_vec;
   for (genvar g = 0; g < ATCE_DEPTH; g++) begin : g_static
      assign static_vec[g] = r_reg.tbl[g].valid && r_reg.tbl[g].state[0];
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   static_keep_a: assert property (!exec |=> ((static_vec & $past(static_vec)) == $past(static_vec)))
      else $error("static entry lost outside a command");

   busy_span_a: assert property (apb_acc && pwrite && paddr == ATCE_ADDR_CTRL2 && !busy |=> busy ##1 !busy)
      else $error("busy not held for exactly the command cycle");

   create_ins_a: assert property (exec && op == ATCE_OP_CREATE && !ex_if.hit_any && cm_if.hit_any
      |=> r_reg.tbl[$past(cm_idx)].valid && r_reg.tbl[$past(cm_idx)].mac == $past(key.mac))
      else $error("create did not store the entry");

   overwrite_a: assert property (exec && op == ATCE_OP_OVERWRITE && ex_if.hit_any
      |=> r_reg.tbl[$past(ex_idx)].port == $past(key.port) && r_reg.result == ATCE_RES_OK)
      else $error("overwrite did not replace the entry");

   erase_gone_a: assert property (exec && op == ATCE_OP_ERASE && ex_if.hit_any
      |=> !r_reg.tbl[$past(ex_idx)].valid)
      else $error("erase left the entry valid");

   search_ret_a: assert property (exec && op == ATCE_OP_SR_FIELD && cm_if.hit_any
      |=> r_reg.res.valid && r_reg.res.mac == $past(r_reg.tbl[cm_idx].mac) && r_reg.walk == $past(cm_idx) + 3'h1)
      else $error("search result fields wrong");

   search_miss_a: assert property (exec && (op == ATCE_OP_SR_FIELD || op == ATCE_OP_SR_EMPTY) && !cm_if.hit_any
      |=> !r_reg.res.valid && r_reg.result == ATCE_RES_NOTFOUND)
      else $error("failed search reported occupied");

   walk_first_a: assert property (exec && op == ATCE_OP_WALK_FIRST |=> r_reg.walk == 3'h0)
      else $error("walk not reset to first entry");

   bad_cmd_a: assert property (exec && r_reg.ctrl2 == ATCE_CMD_WRITE && opsel == 4'h0
      |=> r_reg.result == ATCE_RES_BADCMD)
      else $error("undefined combination accepted");

   lookup_mc_a: assert property (lu_req && lu_if.hit_any && r_reg.tbl[lu_idx].state[1]
      |=> mc_idx == $past(r_reg.tbl[lu_idx].port) ##1 lu_valid && lu_mcast && lu_map == $past(mc_map_data))
      else $error("multicast lookup did not return map entry");

   lookup_uc_a: assert property (lu_req && lu_if.hit_any && !r_reg.tbl[lu_idx].state[1]
      |=> ##1 lu_valid && lu_hit && !lu_mcast && lu_port == $past(r_reg.tbl[lu_idx].port, 2))
      else $error("unicast lookup port wrong");

   apb_ready_a: assert property (apb_acc |=> pready ##1 !pready)
      else $error("pready not a single cycle");

endmodule
`default_nettype wire

// ==== atce_pkg.sv ====
`default_nettype none
package atce_pkg;

   // table geometry
   localparam int ATCE_DEPTH = 8;
   localparam int ATCE_IDXW  = 3;
   localparam int ATCE_NPORT = 26;
   localparam int ATCE_AW    = 12;

   // register indices; byte address is four times the index
   localparam logic [3:0] ATCE_IDX_CTRL0 = 4'h5;
   localparam logic [3:0] ATCE_IDX_CTRL1 = 4'h6;
   localparam logic [3:0] ATCE_IDX_CTRL2 = 4'h7;
   localparam logic [3:0] ATCE_IDX_STAT0 = 4'h8;
   localparam logic [3:0] ATCE_IDX_STAT1 = 4'h9;
   localparam logic [3:0] ATCE_IDX_STAT2 = 4'ha;

   localparam logic [ATCE_AW-1:0] ATCE_ADDR_CTRL0 = {6'h00, ATCE_IDX_CTRL0, 2'h0};
   localparam logic [ATCE_AW-1:0] ATCE_ADDR_CTRL1 = {6'h00, ATCE_IDX_CTRL1, 2'h0};
   localparam logic [ATCE_AW-1:0] ATCE_ADDR_CTRL2 = {6'h00, ATCE_IDX_CTRL2, 2'h0};
   localparam logic [ATCE_AW-1:0] ATCE_ADDR_STAT0 = {6'h00, ATCE_IDX_STAT0, 2'h0};
   localparam logic [ATCE_AW-1:0] ATCE_ADDR_STAT1 = {6'h00, ATCE_IDX_STAT1, 2'h0};
   localparam logic [ATCE_AW-1:0] ATCE_ADDR_STAT2 = {6'h00, ATCE_IDX_STAT2, 2'h0};

   // command field values
   localparam logic [2:0] ATCE_CMD_WRITE  = 3'h0;
   localparam logic [2:0] ATCE_CMD_ERASE  = 3'h1;
   localparam logic [2:0] ATCE_CMD_SEARCH = 3'h2;
   localparam logic [2:0] ATCE_CMD_WALK   = 3'h3;

   // control field values
   localparam logic [3:0] ATCE_CTL_CREATE     = 4'h7;
   localparam logic [3:0] ATCE_CTL_OVERWRITE  = 4'hf;
   localparam logic [3:0] ATCE_CTL_ERASE      = 4'hf;
   localparam logic [3:0] ATCE_CTL_EMPTY      = 4'h0;
   localparam logic [3:0] ATCE_CTL_WALK_ADDR  = 4'h4;
   localparam logic [3:0] ATCE_CTL_WALK_FIRST = 4'h0;
   localparam int         ATCE_SEL_FIELD_BIT  = 3;
   localparam int         ATCE_SEL_MAC_BIT    = 2;
   localparam int         ATCE_SEL_FG_BIT     = 1;
   localparam int         ATCE_SEL_PORT_BIT   = 0;

   // control register 1 field positions
   localparam int ATCE_CTL_STATE_LSB = 30;
   localparam int ATCE_CTL_OPSEL_LSB = 26;
   localparam int ATCE_CTL_PORT_LSB  = 21;
   localparam int ATCE_CTL_FG_LSB    = 16;

   // status register field positions
   localparam int ATCE_ST_BAD_BIT    = 29;
   localparam int ATCE_ST_STATE_LSB  = 27;
   localparam int ATCE_ST_OCC_BIT    = 26;
   localparam int ATCE_ST_PORT_LSB   = 21;
   localparam int ATCE_ST_FG_LSB     = 16;
   localparam int ATCE_ST_BUSY_BIT   = 3;

   // result codes
   localparam logic [2:0] ATCE_RES_OK       = 3'h0;
   localparam logic [2:0] ATCE_RES_NOTFOUND = 3'h1;
   localparam logic [2:0] ATCE_RES_FULL     = 3'h2;
   localparam logic [2:0] ATCE_RES_EXISTS   = 3'h3;
   localparam logic [2:0] ATCE_RES_BADCMD   = 3'h7;

   localparam logic [31:0] ATCE_CTRL_RST = 32'h0000_0000;

   typedef struct packed {
      logic        valid;
      logic [1:0]  state;
      logic [4:0]  port;
      logic [4:0]  fg;
      logic [47:0] mac;
   } atce_entry_t;

   typedef enum logic [1:0] {
      ATCE_IDLE = 2'b01,
      ATCE_EXEC = 2'b10
   } atce_fsm_t;

   typedef enum logic [7:0] {
      ATCE_OP_NONE       = 8'h01,
      ATCE_OP_CREATE     = 8'h02,
      ATCE_OP_OVERWRITE  = 8'h04,
      ATCE_OP_ERASE      = 8'h08,
      ATCE_OP_SR_EMPTY   = 8'h10,
      ATCE_OP_SR_FIELD   = 8'h20,
      ATCE_OP_WALK_ADDR  = 8'h40,
      ATCE_OP_WALK_FIRST = 8'h80
   } atce_op_t;

   typedef struct packed {
      atce_entry_t [ATCE_DEPTH-1:0] tbl;
      logic [31:0]                  ctrl0;
      logic [31:0]                  ctrl1;
      logic [2:0]                   ctrl2;
      atce_fsm_t                    fsm;
      logic [ATCE_IDXW-1:0]         walk;
      atce_entry_t                  res;
      logic [2:0]                   result;
      logic                         ready;
      logic [31:0]                  rdata;
      logic                         slverr;
      logic                         s1_valid;
      logic                         s1_hit;
      logic                         s1_mcast;
      logic [4:0]                   s1_port;
      logic                         lu_valid;
      logic                         lu_hit;
      logic                         lu_mcast;
      logic [4:0]                   lu_port;
      logic [ATCE_NPORT-1:0]        lu_map;
   } atce_regs_t;

endpackage
`default_nettype wire

// ==== atce_match_if.sv ====
`default_nettype none
interface atce_match_if;
   import atce_pkg::*;
   atce_entry_t [ATCE_DEPTH-1:0] tbl;
   atce_entry_t                  key;
   logic                         use_mac;
   logic                         use_fg;
   logic                         use_port;
   logic                         find_free;
   logic [ATCE_IDXW-1:0]         start;
   logic                         hit_any;
   logic [ATCE_IDXW-1:0]         hit_idx;

   modport req (output tbl, key, use_mac, use_fg, use_port, find_free, start, input hit_any, hit_idx);
   modport rsp (input tbl, key, use_mac, use_fg, use_port, find_free, start, output hit_any, hit_idx);
endinterface
`default_nettype wire

// ==== atce_matcher.sv ====
`default_nettype none
module atce_matcher
   import atce_pkg::*;
(
   atce_match_if.rsp m
);

   logic [ATCE_DEPTH-1:0] hit;

   // per-entry compare; entries below start are skipped so a walk resumes
   for (genvar i = 0; i < ATCE_DEPTH; i++) begin : g_ent
      assign hit[i] = (ATCE_IDXW'(i) >= m.start) &&
                      (m.find_free ? !m.tbl[i].valid :
                       (m.tbl[i].valid &&
                        (!m.use_mac  || (m.tbl[i].mac  == m.key.mac)) &&
                        (!m.use_fg   || (m.tbl[i].fg   == m.key.fg)) &&
                        (!m.use_port || (m.tbl[i].port == m.key.port))));
   end

   // lowest index wins
   always_comb begin
      m.hit_any = 1'b0;
      m.hit_idx = '0;
      for (int j = ATCE_DEPTH - 1; j >= 0; j--) begin
         if (hit[j]) begin
            m.hit_any = 1'b1;
            m.hit_idx = ATCE_IDXW'(j);
         end
      end
   end

endmodule
`default_nettype wire

// ==== atce_engine_test.sv ====
`default_nettype none
module atce_engine_test;
   import atce_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [47:0] MAC_A  = 48'h0a0b_0c0d_0e08;
   localparam logic [47:0] MAC_B  = 48'h1122_3344_5501;
   localparam logic [25:0] MC_MAP = 26'h2a5a5a5;

   logic                  pclk = 1'b0;
   logic                  presetn = 1'b0;
   logic [ATCE_AW-1:0]    paddr = '0;
   logic                  psel = 1'b0;
   logic                  penable = 1'b0;
   logic                  pwrite = 1'b0;
   logic [31:0]           pwdata = '0;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   logic                  age_tick = 1'b0;
   logic                  lu_req = 1'b0;
   logic [47:0]           lu_mac = '0;
   logic [4:0]            lu_fg = '0;
   logic                  lu_valid;
   logic                  lu_hit;
   logic                  lu_mcast;
   logic [4:0]            lu_port;
   logic [ATCE_NPORT-1:0] lu_map;
   logic [4:0]            mc_idx;
   logic [ATCE_NPORT-1:0] mc_map;
   logic [31:0]           s0;
   logic [31:0]           s1;
   logic [31:0]           s2;
   int                    failures = 0;
   int                    n_tests = 0;

   always #12.5 pclk = ~pclk;

   // map varies with the index so a wrong index shows
   assign mc_map = MC_MAP ^ {21'h0, mc_idx};

   atce_engine atce_engine_inst (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .age_tick(age_tick),
      .lu_req(lu_req), .lu_mac(lu_mac), .lu_fg(lu_fg), .lu_valid(lu_valid), .lu_hit(lu_hit),
      .lu_mcast(lu_mcast), .lu_port(lu_port), .lu_map(lu_map), .mc_idx(mc_idx), .mc_map_data(mc_map)
   );

   task automatic complete_run();
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // waits are bounded; a stuck slave ends the run
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         failures++;
         $display("wrong value at %0t: no pready", $time);
         complete_run();
      end
   endtask

   task automatic cmd(input logic [2:0] c, input logic [3:0] op, input logic [1:0] st, input logic [4:0] pt,
                      input logic [4:0] fg, input logic [47:0] mac);
      logic e;
      int   i;
      apb(1'b1, ATCE_ADDR_CTRL0, mac[31:0], s0, e);
      apb(1'b1, ATCE_ADDR_CTRL1, {st, op, pt, fg, mac[47:32]}, s0, e);
      // the engine drops a start while busy, so poll first
      for (i = 0; i < 20; i++) begin
         apb(1'b0, ATCE_ADDR_STAT2, 32'h0, s2, e);
         if (s2[ATCE_ST_BUSY_BIT] === 1'b0) break;
      end
      if (i == 20) begin
         failures++;
         $display("wrong value at %0t: busy never cleared", $time);
         complete_run();
      end
      apb(1'b1, ATCE_ADDR_CTRL2, {29'h0, c}, s0, e);
      apb(1'b0, ATCE_ADDR_STAT2, 32'h0, s2, e);
      chk(s2[3], 1'b0, "busy after command");
      apb(1'b0, ATCE_ADDR_STAT1, 32'h0, s1, e);
      apb(1'b0, ATCE_ADDR_STAT0, 32'h0, s0, e);
   endtask

   task automatic lookup(input logic [47:0] mac, input logic [4:0] fg, input logic [32:0] exp);
      int i;
      @(posedge pclk);
      lu_req <= 1'b1;
      lu_mac <= mac;
      lu_fg <= fg;
      @(posedge pclk);
      lu_req <= 1'b0;
      for (i = 0; i < 8; i++) begin
         @(posedge pclk);
         if (lu_valid === 1'b1) break;
      end
      if (i == 8) begin
         failures++;
         $display("wrong value at %0t: no lookup result", $time);
         complete_run();
      end
      chk({31'h0, lu_hit, lu_mcast, lu_port, lu_map}, {31'h0, exp}, "lookup");
   endtask

   task automatic t_create();
      cmd(3'h0, 4'h7, 2'b01, 5'd3, 5'd1, MAC_A);
      chk(s2[2:0], 3'h0, "create a");
      cmd(3'h0, 4'h7, 2'b10, 5'd5, 5'd2, MAC_B);
      chk(s2[2:0], 3'h0, "create b");
      cmd(3'h0, 4'h7, 2'b01, 5'd3, 5'd1, MAC_A);
      chk(s2[2:0], 3'h3, "duplicate create");
      cmd(3'h0, 4'h0, 2'b01, 5'd3, 5'd1, MAC_A);
      chk(s2[2:0], 3'h7, "undefined combination");
      cmd(3'h4, 4'hf, 2'b01, 5'd3, 5'd1, MAC_A);
      chk(s2[2:0], 3'h7, "undefined command");
      $display("create test done");
   endtask

   task automatic t_search();
      logic [3:0] ops [7] = '{4'h9, 4'ha, 4'hc, 4'he, 4'hd, 4'hb, 4'hf};
      foreach (ops[k]) begin
         cmd(3'h3, 4'h0, 2'b00, 5'd0, 5'd0, 48'h0);
         cmd(3'h2, ops[k], 2'b00, 5'd3, 5'd1, MAC_A);
         chk(s2[2:0], 3'h0, "search result");
         chk(s1, {3'h0, 2'b01, 1'b1, 5'd3, 5'd1, MAC_A[47:32]}, "search status1");
         chk(s0, MAC_A[31:0], "search status0");
      end
      cmd(3'h2, 4'h0, 2'b00, 5'd0, 5'd0, 48'h0);
      chk(s2[2:0], 3'h0, "search empty");
      chk(s1[26], 1'b0, "empty occupy");
      // walk sits at 3 here; only a working walk set finds entry 1
      cmd(3'h3, 4'h4, 2'b00, 5'd0, 5'd0, 48'h0000_0000_0001);
      cmd(3'h2, 4'ha, 2'b00, 5'd0, 5'd2, 48'h0);
      chk(s2[2:0], 3'h0, "walk then hit");
      chk(s1, {3'h0, 2'b10, 1'b1, 5'd5, 5'd2, MAC_B[47:32]}, "multicast entry status1");
      chk(s0, MAC_B[31:0], "multicast entry status0");
      // walk past both entries so the port search misses
      cmd(3'h3, 4'h4, 2'b00, 5'd0, 5'd0, 48'h0000_0000_0002);
      cmd(3'h2, 4'h9, 2'b00, 5'd3, 5'd0, 48'h0);
      chk({s2[2:0], s1[26]}, {3'h1, 1'b0}, "walk then miss");
      $display("search test done");
   endtask

   task automatic t_lookup_age();
      logic [31:0] r;
      logic        e;
      lookup(MAC_A, 5'd1, {1'b1, 1'b0, 5'd3, 26'h8});
      lookup(MAC_B, 5'd2, {1'b1, 1'b1, 5'd5, MC_MAP ^ 26'h5});
      lookup(MAC_B, 5'd3, {33'h0});
      @(posedge pclk);
      age_tick <= 1'b1;
      @(posedge pclk);
      age_tick <= 1'b0;
      lookup(MAC_A, 5'd1, {1'b1, 1'b0, 5'd3, 26'h8});
      lookup(MAC_B, 5'd2, {33'h0});
      cmd(3'h0, 4'hf, 2'b01, 5'd7, 5'd1, MAC_A);
      chk(s2[2:0], 3'h0, "overwrite");
      lookup(MAC_A, 5'd1, {1'b1, 1'b0, 5'd7, 26'h80});
      cmd(3'h1, 4'hf, 2'b00, 5'd0, 5'd1, MAC_A);
      chk(s2[2:0], 3'h0, "erase");
      lookup(MAC_A, 5'd1, {33'h0});
      cmd(3'h1, 4'hf, 2'b00, 5'd0, 5'd1, MAC_A);
      chk(s2[2:0], 3'h1, "erase absent");
      apb(1'b0, 12'h3fc, 32'h0, r, e);
      chk({e, r}, {1'b1, 32'h0}, "unmapped read");
      $display("lookup and ageing test done");
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_create();
      t_search();
      t_lookup_age();
      complete_run();
   end
endmodule
`default_nettype wire
